// File: logic/drive_status_pkg.sv
// Shared constants for the drive status and reference word block
`default_nettype none
package drive_status_pkg;
	localparam int WORD_W = 16;
	// Status word bit positions
	localparam int ST_CTRL_READY = 0;
	localparam int ST_DRIVE_READY = 1;
	localparam int ST_STANDBY = 2;
	localparam int ST_TRIP = 3;
	localparam int ST_SPARE4 = 4;
	localparam int ST_SPARE5 = 5;
	localparam int ST_TRIP_LOCK = 6;
	localparam int ST_WARNING = 7;
	localparam int ST_ON_REF = 8;
	localparam int ST_SERIAL_CTRL = 9;
	localparam int ST_IN_RANGE = 10;
	localparam int ST_RUNNING = 11;
	localparam int ST_SPARE12 = 12;
	localparam int ST_VOLTAGE = 13;
	localparam int ST_CURRENT_LIMIT = 14;
	localparam int ST_THERMAL = 15;
	// Control word data valid bit
	localparam int CW_DATA_VALID = 10;
	// Control word coast (active low) and start bits
	localparam int CW_COAST = 3;
	localparam int CW_START = 6;
	// Reference scaling: 0x4000 is full span
	localparam logic [15:0] REF_FULL = 16'h4000;
	localparam int REF_SHIFT = 14;
	// Protocol selection codes
	localparam logic [0:0] PROTO_NATIVE = 1'h0;
	localparam logic [0:0] PROTO_MODBUS = 1'h1;
	// Station address range and default
	localparam logic [6:0] ADDR_MAX = 7'h7e;
	localparam logic [6:0] ADDR_DEFAULT = 7'h01;
	// Overcurrent trip delay
	localparam int OC_DELAY_MS = 1;
	localparam int CLK_HZ = 40000000;
	localparam int OC_DELAY_CYCLES = OC_DELAY_MS * (CLK_HZ / 1000);
endpackage
`default_nettype wire

// File: logic/drive_status_words.sv
// Drive status word, reference and output frequency words for the serial link
`default_nettype none
module drive_status_words
	import drive_status_pkg::*;
#(
	parameter int OC_DELAY = OC_DELAY_CYCLES
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic coast_pin,
	input wire logic hand_mode,
	input wire logic panel_halt,
	input wire logic fault_event,
	input wire logic trip_lock,
	input wire logic any_warning,
	input wire logic dc_voltage_bad,
	input wire logic motor_overtemp,
	input wire logic drive_overtemp,
	input wire logic thermistor_hot,
	input wire logic start_pin,
	input wire logic [15:0] current_limit_setting,
	input wire logic [15:0] output_current,
	input wire logic [15:0] actual_speed,
	input wire logic [15:0] out_freq,
	input wire logic [15:0] freq_low_limit,
	input wire logic [15:0] freq_high_limit,
	input wire logic [15:0] ref_min,
	input wire logic [15:0] ref_max,
	input wire logic rx_valid,
	input wire logic [15:0] rx_control_word,
	input wire logic [15:0] speed_setpoint_word,
	input wire logic trip_reset,
	input wire logic protocol_sel,
	input wire logic [6:0] station_addr_in,
	input wire logic addr_write,
	input wire logic reply_strobe,
	output logic [15:0] drive_status_word,
	output logic [15:0] output_frequency_word,
	output logic [15:0] speed_target,
	output logic reverse_request,
	output logic [15:0] control_word,
	output logic control_valid,
	output logic native_drive_protocol,
	output logic [6:0] station_addr,
	output logic reply_valid
);
	if (OC_DELAY < 1) begin : g_bad_delay
		$error("OC_DELAY must be at least one cycle");
	end
	// Pin synchronisers
	logic [1:0] coast_s_q, start_s_q, halt_s_q, hand_s_q;
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			coast_s_q <= 2'h3;
			start_s_q <= 2'h0;
			halt_s_q <= 2'h0;
			hand_s_q <= 2'h0;
		end else begin
			coast_s_q <= {coast_s_q[0], coast_pin};
			start_s_q <= {start_s_q[0], start_pin};
			halt_s_q <= {halt_s_q[0], panel_halt};
			hand_s_q <= {hand_s_q[0], hand_mode};
		end
	end
	wire coast_n = coast_s_q[1];
	wire start_s = start_s_q[1];
	// Control word latch, used only when data valid set
	logic [15:0] cw_q;
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			cw_q <= 16'h0000;
		else if (rx_valid && rx_control_word[CW_DATA_VALID])
			cw_q <= rx_control_word;
	end
	assign control_word = cw_q;
	assign control_valid = cw_q[CW_DATA_VALID];
	wire serial_coast = (cw_q[CW_COAST] == 1'b0) && cw_q[CW_DATA_VALID];
	wire serial_start = cw_q[CW_START] && cw_q[CW_DATA_VALID];
	// Overcurrent timer and trip latch
	wire over_i = output_current > current_limit_setting;
	logic [31:0] oc_cnt_q;
	logic oc_trip;
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			oc_cnt_q <= 32'h0;
		else if (!over_i)
			oc_cnt_q <= 32'h0;
		else if (oc_cnt_q < 32'(OC_DELAY))
			oc_cnt_q <= oc_cnt_q + 32'h1;
	end
	assign oc_trip = over_i && (oc_cnt_q >= 32'(OC_DELAY) - 32'h1);
	logic trip_q;
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			trip_q <= 1'b0;
		else if (fault_event || oc_trip)
			trip_q <= 1'b1;
		else if (trip_reset && !trip_lock)
			trip_q <= 1'b0;
	end
	// Protocol and address settings
	logic proto_q;
	logic [6:0] addr_q;
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			proto_q <= PROTO_NATIVE;
			addr_q <= ADDR_DEFAULT;
		end else if (addr_write) begin
			proto_q <= protocol_sel;
			if (protocol_sel == PROTO_MODBUS || station_addr_in <= ADDR_MAX)
				addr_q <= station_addr_in;
		end
	end
	assign native_drive_protocol = (proto_q == PROTO_NATIVE);
	assign station_addr = addr_q;
	// Reference scaling
	scale_if ref_bus ();
	assign ref_bus.raw = speed_setpoint_word;
	assign ref_bus.lo = ref_min;
	assign ref_bus.hi = ref_max;
	ref_scaler u_ref (
		.mclk(mclk),
		.resetn(resetn),
		.s(ref_bus)
	);
	assign speed_target = ref_bus.mag;
	assign reverse_request = ref_bus.neg;
	// Output frequency scaling onto 0..0x4000 of low..high span
	function automatic logic [15:0] freq_word(input logic [15:0] f, input logic [15:0] lo,
		input logic [15:0] hi);
		logic [16:0] span;
		logic [31:0] num;
		span = {1'b0, hi} - {1'b0, lo};
		num = (f > lo) ? 32'(f - lo) << REF_SHIFT : 32'h0;
		if (span == 17'h0)
			freq_word = 16'h0000;
		else
			freq_word = 16'(num / 32'(span));
	endfunction
	// Live status assembly
	logic [15:0] st_d;
	always_comb begin
		st_d = 16'h0000;
		st_d[ST_CTRL_READY] = !trip_q;
		st_d[ST_DRIVE_READY] = !trip_q && (!coast_n || serial_coast);
		st_d[ST_STANDBY] = !trip_q && coast_n && !serial_coast && !trip_lock;
		st_d[ST_TRIP] = trip_q;
		st_d[ST_TRIP_LOCK] = trip_lock;
		st_d[ST_WARNING] = any_warning;
		st_d[ST_ON_REF] = (actual_speed == speed_target);
		st_d[ST_SERIAL_CTRL] = !halt_s_q[1] && !hand_s_q[1];
		st_d[ST_IN_RANGE] = (out_freq > freq_low_limit) && (out_freq < freq_high_limit);
		st_d[ST_RUNNING] = start_s || serial_start || (out_freq != 16'h0000);
		st_d[ST_VOLTAGE] = dc_voltage_bad;
		st_d[ST_CURRENT_LIMIT] = over_i;
		st_d[ST_THERMAL] = motor_overtemp || drive_overtemp || thermistor_hot;
	end
	logic [15:0] status_q, freq_q;
	logic reply_q;
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			status_q <= 16'h0000;
			freq_q <= 16'h0000;
			reply_q <= 1'b0;
		end else begin
			reply_q <= reply_strobe;
			if (reply_strobe) begin
				status_q <= st_d;
				freq_q <= freq_word(out_freq, freq_low_limit, freq_high_limit);
			end
		end
	end
	assign drive_status_word = status_q;
	assign output_frequency_word = freq_q;
	assign reply_valid = reply_q;
	// Assertions
	property p_ready_trip;
		@(posedge mclk) disable iff (!resetn)
		reply_valid |-> drive_status_word[ST_CTRL_READY] != drive_status_word[ST_TRIP];
	endproperty
	a_ready_trip: assert property (p_ready_trip) else $error("ready and trip agree");
	property p_trip_hold;
		@(posedge mclk) disable iff (!resetn)
		(trip_q && !trip_reset) |=> trip_q;
	endproperty
	a_trip_hold: assert property (p_trip_hold) else $error("trip dropped");
	property p_spare;
		@(posedge mclk) disable iff (!resetn)
		reply_valid |-> !drive_status_word[ST_SPARE4] && !drive_status_word[ST_SPARE5]
			&& !drive_status_word[ST_SPARE12];
	endproperty
	a_spare: assert property (p_spare) else $error("spare bit set");
	property p_warn;
		@(posedge mclk) disable iff (!resetn)
		reply_strobe |=> drive_status_word[ST_WARNING] == $past(any_warning);
	endproperty
	a_warn: assert property (p_warn) else $error("warning bit wrong");
	property p_cw_ignore;
		@(posedge mclk) disable iff (!resetn)
		(rx_valid && !rx_control_word[CW_DATA_VALID]) |=> $stable(control_word);
	endproperty
	a_cw_ignore: assert property (p_cw_ignore) else $error("invalid control word taken");
	property p_oc_trip;
		@(posedge mclk) disable iff (!resetn)
		oc_trip |=> trip_q;
	endproperty
	a_oc_trip: assert property (p_oc_trip) else $error("no overcurrent trip");
	property p_addr;
		@(posedge mclk) disable iff (!resetn)
		native_drive_protocol |-> station_addr <= ADDR_MAX;
	endproperty
	a_addr: assert property (p_addr) else $error("address out of range");
	property p_trip_locked;
		@(posedge mclk) disable iff (!resetn)
		(trip_q && trip_lock) |=> trip_q;
	endproperty
	a_trip_locked: assert property (p_trip_locked) else $error("trip cleared under lock");
	property p_trip_nrdy;
		@(posedge mclk) disable iff (!resetn)
		(reply_strobe && trip_q) |=> !drive_status_word[ST_DRIVE_READY]
			&& !drive_status_word[ST_STANDBY];
	endproperty
	a_trip_nrdy: assert property (p_trip_nrdy) else $error("ready while tripped");
	property p_coast_rdy;
		@(posedge mclk) disable iff (!resetn)
		(reply_strobe && !trip_q && !coast_n) |=> drive_status_word[ST_DRIVE_READY]
			&& !drive_status_word[ST_STANDBY];
	endproperty
	a_coast_rdy: assert property (p_coast_rdy) else $error("coast not reported");
	property p_lock_bit;
		@(posedge mclk) disable iff (!resetn)
		reply_strobe |=> drive_status_word[ST_TRIP_LOCK] == $past(trip_lock);
	endproperty
	a_lock_bit: assert property (p_lock_bit) else $error("trip lock bit wrong");
	property p_on_ref;
		@(posedge mclk) disable iff (!resetn)
		reply_strobe |=> drive_status_word[ST_ON_REF]
			== ($past(actual_speed) == $past(speed_target));
	endproperty
	a_on_ref: assert property (p_on_ref) else $error("on reference bit wrong");
	property p_local;
		@(posedge mclk) disable iff (!resetn)
		(reply_strobe && (halt_s_q[1] || hand_s_q[1])) |=> !drive_status_word[ST_SERIAL_CTRL];
	endproperty
	a_local: assert property (p_local) else $error("serial control while local");
	property p_at_limit;
		@(posedge mclk) disable iff (!resetn)
		(reply_strobe && (out_freq <= freq_low_limit || out_freq >= freq_high_limit))
			|=> !drive_status_word[ST_IN_RANGE];
	endproperty
	a_at_limit: assert property (p_at_limit) else $error("in range at a limit");
	property p_running;
		@(posedge mclk) disable iff (!resetn)
		(reply_strobe && out_freq != 16'h0000) |=> drive_status_word[ST_RUNNING];
	endproperty
	a_running: assert property (p_running) else $error("running bit low");
	property p_voltage;
		@(posedge mclk) disable iff (!resetn)
		reply_strobe |=> drive_status_word[ST_VOLTAGE] == $past(dc_voltage_bad);
	endproperty
	a_voltage: assert property (p_voltage) else $error("voltage bit wrong");
	property p_ilim_bit;
		@(posedge mclk) disable iff (!resetn)
		reply_strobe |=> drive_status_word[ST_CURRENT_LIMIT]
			== ($past(output_current) > $past(current_limit_setting));
	endproperty
	a_ilim_bit: assert property (p_ilim_bit) else $error("current limit bit wrong");
	property p_thermal;
		@(posedge mclk) disable iff (!resetn)
		reply_strobe |=> drive_status_word[ST_THERMAL]
			== ($past(motor_overtemp) || $past(drive_overtemp) || $past(thermistor_hot));
	endproperty
	a_thermal: assert property (p_thermal) else $error("thermal bit wrong");
	property p_cw_take;
		@(posedge mclk) disable iff (!resetn)
		(rx_valid && rx_control_word[CW_DATA_VALID]) |=> control_word == $past(rx_control_word);
	endproperty
	a_cw_take: assert property (p_cw_take) else $error("valid control word lost");
	// Reply handshake: strobe taken, then valid for one cycle unless strobed again
	sequence s_strobe_taken;
		reply_strobe;
	endsequence
	sequence s_valid_one_cycle;
		reply_valid ##1 (!reply_valid || $past(reply_strobe));
	endsequence
	property p_reply;
		@(posedge mclk) disable iff (!resetn)
		s_strobe_taken |=> s_valid_one_cycle;
	endproperty
	a_reply: assert property (p_reply) else $error("reply pulse wrong");
endmodule // drive_status_words
`default_nettype wire

// File: logic/ref_scaler.sv
// Maps a signed 16-bit word onto a min..max span (0x4000 is 100 percent)
`default_nettype none
module ref_scaler
	import drive_status_pkg::*;
(
	input wire logic mclk,
	input wire logic resetn,
	scale_if.scaler s
);
	logic [15:0] abs_v;
	logic [16:0] span;
	logic [33:0] prod;
	logic [15:0] mag_q;
	logic neg_q;
	always_comb begin
		abs_v = s.raw[15] ? 16'(-s.raw) : 16'(s.raw);
		span = {1'b0, s.hi} - {1'b0, s.lo};
		prod = 34'(abs_v) * 34'(span);
	end
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			mag_q <= 16'h0000;
			neg_q <= 1'b0;
		end else begin
			mag_q <= 16'(({18'h00000, s.lo} + (prod >> REF_SHIFT)));
			neg_q <= s.raw[15];
		end
	end
	assign s.mag = mag_q;
	assign s.neg = neg_q;
endmodule // ref_scaler
`default_nettype wire

// File: logic/scale_if.sv
// Signals between the top block and the reference scaler
`default_nettype none
interface scale_if;
	logic signed [15:0] raw;
	logic [15:0] lo;
	logic [15:0] hi;
	logic [15:0] mag;
	logic neg;
	modport user (output raw, output lo, output hi, input mag, input neg);
	modport scaler (input raw, input lo, input hi, output mag, output neg);
endinterface
`default_nettype wire

// File: testbench/drive_status_words_tb_top.sv
// Self-checking bench for the drive status and reference words
`default_nettype none
`define CHK(a, b) begin \
	cmp_count++; \
	if ((a) !== (b)) begin \
		num_errors++; \
		$display("ERROR %0t got %h want %h", $time, (a), (b)); \
	end \
end
module drive_status_words_tb_top import drive_status_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk, resetn, fault_event, trip_reset, rx_valid, protocol_sel, addr_write;
	logic reply_strobe, reverse_request, control_valid, native_drive_protocol, reply_valid;
	logic [9:0] fl;
	logic [6:0] station_addr_in, station_addr;
	logic [15:0] output_current, actual_speed, out_freq, rx_control_word, speed_setpoint_word;
	logic [15:0] drive_status_word, output_frequency_word, speed_target, control_word;
	logic [15:0] current_limit_setting, freq_low_limit, freq_high_limit, ref_min, ref_max;
	int num_errors = 0, cmp_count = 0, cyc = 0;
	typedef struct packed {logic [9:0] fl; logic [15:0] f; logic [15:0] st; logic [15:0] fw;} row_s;
	// Flags: coast_pin halt hand warn dc motor drive thermistor start lock
	row_s rows [10] = '{
		'{10'h200, 16'h0000, 16'h0305, 16'h0000},
		'{10'h200, 16'h0019, 16'h0f05, 16'h2000},
		'{10'h000, 16'h0000, 16'h0303, 16'h0000},
		'{10'h260, 16'h0032, 16'h2b85, 16'h4000},
		'{10'h300, 16'h0000, 16'h0105, 16'h0000},
		'{10'h280, 16'h0000, 16'h0105, 16'h0000},
		'{10'h210, 16'h0000, 16'h8305, 16'h0000},
		'{10'h208, 16'h0000, 16'h8305, 16'h0000},
		'{10'h204, 16'h0000, 16'h8305, 16'h0000},
		'{10'h202, 16'h0000, 16'h0b05, 16'h0000}
	};
	drive_status_words #(.OC_DELAY(4)) drive_status_words_inst (
		.mclk, .resetn, .coast_pin(fl[9]), .panel_halt(fl[8]), .hand_mode(fl[7]),
		.any_warning(fl[6]), .dc_voltage_bad(fl[5]), .motor_overtemp(fl[4]),
		.drive_overtemp(fl[3]), .thermistor_hot(fl[2]), .start_pin(fl[1]), .trip_lock(fl[0]),
		.fault_event, .current_limit_setting, .output_current, .actual_speed,
		.out_freq, .freq_low_limit, .freq_high_limit, .ref_min,
		.ref_max, .rx_valid, .rx_control_word, .speed_setpoint_word, .trip_reset,
		.protocol_sel, .station_addr_in, .addr_write, .reply_strobe, .drive_status_word,
		.output_frequency_word, .speed_target, .reverse_request, .control_word,
		.control_valid, .native_drive_protocol, .station_addr, .reply_valid
	);
	serial_master serial_master_inst (
		.mclk, .rx_valid, .rx_control_word, .speed_setpoint_word, .reply_strobe,
		.protocol_sel, .station_addr_in, .addr_write
	);
	task automatic print_verdict();
		$display("Compares %0d, errors %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic reply(input logic [15:0] st, input logic [15:0] fw);
		serial_master_inst.strobe();
		@(negedge mclk);
		`CHK(reply_valid, 1'b1)
		`CHK(drive_status_word, st)
		`CHK(output_frequency_word, fw)
		@(negedge mclk);
		`CHK(reply_valid, 1'b0)
	endtask
	task automatic chk_ref(input logic [14:0] m, input logic n, input logic [15:0] t);
		serial_master_inst.set_ref(m, n);
		wait_cyc(4);
		@(negedge mclk);
		`CHK(speed_target, t)
		`CHK(reverse_request, n)
	endtask
	task automatic clear_trip();
		@(posedge mclk);
		trip_reset <= 1'b1;
		wait_cyc(2);
		trip_reset <= 1'b0;
	endtask
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			num_errors++;
			print_verdict();
		end
	end
	initial begin
		resetn = 1'b0;
		fl = 10'h200;
		fault_event = 1'b0;
		trip_reset = 1'b0;
		output_current = 16'h0000;
		actual_speed = 16'h01f4;
		out_freq = 16'h0000;
		current_limit_setting = 16'h0064;
		freq_low_limit = 16'h0000;
		freq_high_limit = 16'h0032;
		ref_min = 16'h0000;
		ref_max = 16'h03e8;
		repeat (2) @(posedge mclk);
		resetn <= 1'b1;
		@(negedge mclk);
		`CHK(station_addr, 7'h01)
		`CHK(native_drive_protocol, 1'b1)
		serial_master_inst.setup(7'h7e, 1'b0);
		serial_master_inst.setup(7'h7f, 1'b0);
		@(negedge mclk);
		`CHK(station_addr, 7'h7e)
		serial_master_inst.setup(7'h05, 1'b1);
		@(negedge mclk);
		`CHK(native_drive_protocol, 1'b0)
		serial_master_inst.setup(7'h00, 1'b0);
		@(negedge mclk);
		`CHK(station_addr, 7'h00)
		`CHK(native_drive_protocol, 1'b1)
		chk_ref(15'h2000, 1'b0, 16'h01f4);
		foreach (rows[i]) begin
			@(posedge mclk);
			fl <= rows[i].fl;
			out_freq <= rows[i].f;
			wait_cyc(4);
			reply(rows[i].st, rows[i].fw);
		end
		@(posedge mclk);
		fl <= 10'h200;
		output_current <= 16'h0064;
		wait_cyc(4);
		reply(16'h0305, 16'h0000);
		@(posedge mclk);
		output_current <= 16'h0065;
		reply(16'h4305, 16'h0000);
		wait_cyc(8);
		reply(16'h4308, 16'h0000);
		@(posedge mclk);
		output_current <= 16'h0000;
		clear_trip();
		reply(16'h0305, 16'h0000);
		@(posedge mclk);
		fl <= 10'h201;
		fault_event <= 1'b1;
		@(posedge mclk);
		fault_event <= 1'b0;
		clear_trip();
		reply(16'h0348, 16'h0000);
		@(posedge mclk);
		fl <= 10'h200;
		clear_trip();
		reply(16'h0305, 16'h0000);
		serial_master_inst.send_cw(16'h047f);
		serial_master_inst.send_cw(16'h0077);
		@(negedge mclk);
		`CHK(control_word, 16'h047f)
		`CHK(control_valid, 1'b1)
		reply(16'h0b05, 16'h0000);
		serial_master_inst.send_cw(16'h0477);
		reply(16'h0b03, 16'h0000);
		chk_ref(15'h2000, 1'b1, 16'h01f4);
		chk_ref(15'h4000, 1'b0, 16'h03e8);
		reply(16'h0a03, 16'h0000);
		@(posedge mclk);
		actual_speed <= 16'h03e8;
		reply(16'h0b03, 16'h0000);
		chk_ref(15'h0000, 1'b0, 16'h0000);
		@(posedge mclk);
		freq_low_limit <= 16'h000a;
		out_freq <= 16'h000a;
		reply(16'h0a03, 16'h0000);
		@(posedge mclk);
		out_freq <= 16'h001e;
		reply(16'h0e03, 16'h2000);
		@(posedge mclk);
		ref_min <= 16'h0064;
		chk_ref(15'h2000, 1'b0, 16'h0226);
		@(posedge mclk);
		resetn <= 1'b0;
		@(negedge mclk);
		`CHK(drive_status_word, 16'h0000)
		`CHK(station_addr, 7'h01)
		`CHK(control_word, 16'h0000)
		`CHK(reply_valid, 1'b0)
		@(posedge mclk);
		resetn <= 1'b1;
		reply(16'h0e05, 16'h2000);
		`CHK(native_drive_protocol, 1'b1)
		print_verdict();
	end
endmodule // drive_status_words_tb_top
`default_nettype wire

// File: testbench/serial_master.sv
// Serial master model that feeds the drive's link inputs
`default_nettype none
module serial_master (
	input wire logic mclk,
	output var logic rx_valid,
	output var logic [15:0] rx_control_word,
	output var logic [15:0] speed_setpoint_word,
	output var logic reply_strobe,
	output var logic protocol_sel,
	output var logic [6:0] station_addr_in,
	output var logic addr_write
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		rx_valid = 1'b0;
		rx_control_word = 16'h0000;
		speed_setpoint_word = 16'h0000;
		reply_strobe = 1'b0;
		protocol_sel = 1'b0;
		station_addr_in = 7'h00;
		addr_write = 1'b0;
	end
	// Address and protocol go in before any other traffic
	task automatic setup(input logic [6:0] a, input logic p);
		@(posedge mclk);
		addr_write <= 1'b1;
		station_addr_in <= a;
		protocol_sel <= p;
		@(posedge mclk);
		addr_write <= 1'b0;
		station_addr_in <= ~a;
	endtask
	// Magnitude up to 32767, reversal sent as two's complement
	task automatic set_ref(input logic [14:0] mag, input logic neg);
		@(posedge mclk);
		speed_setpoint_word <= neg ? ~{1'b0, mag} + 16'h0001 : {1'b0, mag};
	endtask
	// Released data lines show the inverse of the last word
	task automatic send_cw(input logic [15:0] w);
		@(posedge mclk);
		rx_valid <= 1'b1;
		rx_control_word <= w;
		@(posedge mclk);
		rx_valid <= 1'b0;
		rx_control_word <= ~w;
	endtask
	task automatic strobe();
		@(posedge mclk);
		reply_strobe <= 1'b1;
		@(posedge mclk);
		reply_strobe <= 1'b0;
	endtask
endmodule // serial_master
`default_nettype wire
